//--- iac_field_regs.svh
`ifndef IAC_FIELD_REGS_SVH
`define IAC_FIELD_REGS_SVH

// Register indices; the byte address is four times the index.
`define IDX_DSP_CONTROL 12'h0FFF
`define IDX_SELECTION   12'h0FFE
`define IDX_LEVEL_ABS   12'h0FFC
`define IDX_ABSORBER    12'h0FFB
`define IDX_STATUS      12'h0F00

// Reset values of the control words.
`define RST_DSP_CONTROL 16'h0038
`define RST_SELECTION   16'h0000
`define RST_LEVEL_ABS   16'h7BA6
`define RST_ABSORBER    16'h0ACD

// Field positions in the control words.
`define F_PLL_BYPASS 1
`define F_PLL_LO     2
`define F_PLL_HI     5
`define F_SRC_LO     5
`define F_SRC_HI     6
`define F_FMT_LO     7
`define F_FMT_HI     9
`define F_LTHR_LO    0
`define F_LTHR_HI    3
`define F_LFF_LO     4
`define F_LFF_HI     5
`define F_LSTR_LO    6
`define F_LSTR_HI    7
`define F_LDEV_LO    8
`define F_LDEV_HI    9
`define F_LSWEEP     10
`define F_ATHR_LO    0
`define F_ATHR_HI    2
`define F_AFF_LO     3
`define F_AFF_HI     5
`define F_ASUP_LO    6
`define F_ASUP_HI    8
`define F_ACMP_LO    9
`define F_ACMP_HI    10
`define F_AAGC       11
`define F_AGDC_LO    12
`define F_AGDC_HI    14
`define F_ATRIG      15
`define ST_REJECT    0

`endif

//--- iac_field_pkg.sv
package iac_field_pkg;

   // Decoded level-based absorber settings.
   typedef struct packed {
      logic              thr_off;
      logic [6:0]        thr_bin;
      logic signed [2:0] ff_delay;
      logic [3:0]        stretch;
      logic [6:0]        dev_khz;
      logic              sweep_en;
   } level_cfg_t;

   // Decoded frequency-based absorber settings.
   typedef struct packed {
      logic [11:0] thr_bin;
      logic [11:0] ff_bin;
      logic [2:0]  supp_pulse;
      logic [2:0]  supp_stretch;
      logic        supp_stretch_valid;
      logic [2:0]  comp_delay;
      logic [3:0]  gdc_delay;
      logic        agc_fine;
      logic        trigger_out;
   } absorber_cfg_t;

   typedef enum logic [1:0] {
      src_internal_stereo_path,
      src_external_cd_serial_input,
      src_external_digital_audio
   } audio_source_t;

   typedef enum logic [2:0] {
      fmt_internal_lsb_first,
      fmt_lsb_16,
      fmt_lsb_18,
      fmt_lsb_20,
      fmt_i2s,
      fmt_third_digital_format
   } audio_format_t;

endpackage

//--- level_field_decode.sv
`timescale 1ns/100ps
`include "iac_field_regs.svh"

module level_field_decode (
   input  wire logic [15:0]               word,
   output iac_field_pkg::level_cfg_t      cfg
);

   // Maps each code of the level absorber word onto its setting.
   always_comb begin
      cfg          = '0;
      cfg.thr_off  = (word[`F_LTHR_HI:`F_LTHR_LO] == 4'h0);
      case (word[`F_LTHR_HI:`F_LTHR_LO])
         4'h1:    cfg.thr_bin = 7'h02;
         4'h2:    cfg.thr_bin = 7'h03;
         4'h3:    cfg.thr_bin = 7'h04;
         4'h4:    cfg.thr_bin = 7'h05;
         4'h5:    cfg.thr_bin = 7'h06;
         4'h6:    cfg.thr_bin = 7'h08;
         4'h7:    cfg.thr_bin = 7'h0A;
         4'h8:    cfg.thr_bin = 7'h0D;
         4'h9:    cfg.thr_bin = 7'h10;
         4'hA:    cfg.thr_bin = 7'h14;
         4'hB:    cfg.thr_bin = 7'h1A;
         4'hC:    cfg.thr_bin = 7'h20;
         4'hD:    cfg.thr_bin = 7'h28;
         4'hE:    cfg.thr_bin = 7'h34;
         4'hF:    cfg.thr_bin = 7'h40;
         default: cfg.thr_bin = 7'h00;
      endcase
      cfg.ff_delay = 3'(word[`F_LFF_HI:`F_LFF_LO]) - 3'h2;
      cfg.stretch  = 4'h9 + {1'b0, word[`F_LSTR_HI:`F_LSTR_LO], 1'b0};
      case (word[`F_LDEV_HI:`F_LDEV_LO])
         2'h0:    cfg.dev_khz = 7'd42;
         2'h1:    cfg.dev_khz = 7'd48;
         2'h2:    cfg.dev_khz = 7'd57;
         default: cfg.dev_khz = 7'd70;
      endcase
      cfg.sweep_en = word[`F_LSWEEP];
   end

endmodule

//--- absorber_field_decode.sv
`timescale 1ns/100ps
`include "iac_field_regs.svh"

module absorber_field_decode (
   input  wire logic [15:0]               word,
   output iac_field_pkg::absorber_cfg_t   cfg
);

   // Maps each code of the absorber word onto its setting.
   always_comb begin
      cfg = '0;
      case (word[`F_ATHR_HI:`F_ATHR_LO])
         3'h4:    cfg.thr_bin = 12'h070;
         3'h5:    cfg.thr_bin = 12'h080;
         3'h6:    cfg.thr_bin = 12'h09C;
         3'h7:    cfg.thr_bin = 12'h0C0;
         3'h0:    cfg.thr_bin = 12'h0E0;
         3'h1:    cfg.thr_bin = 12'h100;
         3'h2:    cfg.thr_bin = 12'h130;
         default: cfg.thr_bin = 12'h160;
      endcase
      case (word[`F_AFF_HI:`F_AFF_LO])
         3'h7:    cfg.ff_bin = 12'h006;
         3'h6:    cfg.ff_bin = 12'h008;
         3'h5:    cfg.ff_bin = 12'h00C;
         3'h4:    cfg.ff_bin = 12'h010;
         3'h3:    cfg.ff_bin = 12'h018;
         3'h2:    cfg.ff_bin = 12'h020;
         3'h1:    cfg.ff_bin = 12'h030;
         default: cfg.ff_bin = 12'h000;
      endcase
      // Pulse length runs 0..7 as code ^ 5; stretch is one less, or 0 and marked invalid when pulse is 0.
      cfg.supp_pulse         = word[`F_ASUP_HI:`F_ASUP_LO] ^ 3'h5;
      cfg.supp_stretch_valid = (cfg.supp_pulse != 3'h0);
      cfg.supp_stretch       = cfg.supp_stretch_valid ? cfg.supp_pulse - 3'h1 : 3'h0;
      cfg.comp_delay         = 3'(word[`F_ACMP_HI:`F_ACMP_LO] ^ 2'h2) + 3'h2;
      cfg.gdc_delay          = 4'h8 + {1'b0, word[`F_AGDC_HI:`F_AGDC_LO] ^ 3'h4};
      cfg.agc_fine           = word[`F_AAGC];
      cfg.trigger_out        = word[`F_ATRIG];
   end

endmodule

//--- iac_pll_audio_field_decode.sv
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`include "iac_field_regs.svh"


module iac_pll_audio_field_decode (
   input  wire logic                      clk,
   input  wire logic                      srst,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [13:2]               wb_adr_i,
   input  wire logic [31:0]               wb_dat_i,
   input  wire logic [3:0]                wb_sel_i,
   output logic [31:0]                    wb_dat_o,
   output logic                           wb_ack_o,
   output iac_field_pkg::level_cfg_t      level_cfg,
   output iac_field_pkg::absorber_cfg_t   absorber_cfg,
   output logic [7:0]                     pll_div_n,
   output logic                           pll_bypass,
   output iac_field_pkg::audio_source_t   audio_source,
   output iac_field_pkg::audio_format_t   audio_format
);

   logic [15:0]                  dsp_control_word_reg;
   logic [15:0]                  selection_reg;
   logic [15:0]                  level_absorber_word_reg;
   logic [15:0]                  absorber_word_reg;
   logic                         reject_reg;
   logic [15:0]                  selection_next;
   logic [15:0]                  sel_merged;
   logic [31:0]                  rd_data;
   logic                         req;
   logic                         wr;
   logic                         bad_fmt_wr;
   logic                         reject_clr;
   iac_field_pkg::level_cfg_t    level_dec;
   iac_field_pkg::absorber_cfg_t absorber_dec;
   logic                         srst_d;

   // Byte-lane merge of a write into a 16-bit control word.
   function automatic logic [15:0] merge(input logic [15:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0]  lanes);
      logic [15:0] m;
      m = old_w;
      if (lanes[0]) begin
         m[7:0] = new_w[7:0];
      end
      if (lanes[1]) begin
         m[15:8] = new_w[15:8];
      end
      return m;
   endfunction

   // Division factor chosen by the 4-bit PLL code.
   function automatic logic [7:0] pll_factor(input logic [3:0] code);
      logic [7:0] n;
      case (code)
         4'h0:    n = 8'd93;
         4'h1:    n = 8'd99;
         4'h2:    n = 8'd106;
         4'h3:    n = 8'd113;
         4'h4:    n = 8'd121;
         4'h5:    n = 8'd126;
         4'h6:    n = 8'd132;
         4'h7:    n = 8'd137;
         4'h8:    n = 8'd143;
         4'h9:    n = 8'd148;
         4'hA:    n = 8'd154;
         4'hB:    n = 8'd159;
         4'hC:    n = 8'd165;
         4'hD:    n = 8'd170;
         4'hE:    n = 8'd176;
         default: n = 8'd181;
      endcase
      return n;
   endfunction

   // Codes 110 and 111 name no input format.
   function automatic logic fmt_reserved(input logic [2:0] code);
      return code[2:1] == 2'b11;
   endfunction

   // Input format chosen by a defined 3-bit format code.
   function automatic iac_field_pkg::audio_format_t fmt_decode(input logic [2:0] code);
      iac_field_pkg::audio_format_t f;
      case (code)
         3'h1:    f = iac_field_pkg::fmt_lsb_16;
         3'h2:    f = iac_field_pkg::fmt_lsb_18;
         3'h3:    f = iac_field_pkg::fmt_lsb_20;
         3'h4:    f = iac_field_pkg::fmt_i2s;
         3'h5:    f = iac_field_pkg::fmt_third_digital_format;
         default: f = iac_field_pkg::fmt_internal_lsb_first;
      endcase
      return f;
   endfunction

   // A request is served once; ack drops in the cycle after it.
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr  = req & wb_we_i;

   // Selection writes that carry a reserved format keep the old format bits.
   always_comb begin
      sel_merged     = merge(selection_reg, wb_dat_i, wb_sel_i);
      selection_next = sel_merged;
      bad_fmt_wr     = 1'b0;
      if (wr && wb_adr_i == `IDX_SELECTION) begin
         if (fmt_reserved(sel_merged[`F_FMT_HI:`F_FMT_LO])) begin
            bad_fmt_wr                         = 1'b1;
            selection_next[`F_FMT_HI:`F_FMT_LO] = selection_reg[`F_FMT_HI:`F_FMT_LO];
         end
      end
   end

   assign reject_clr = wr && wb_adr_i == `IDX_STATUS && wb_sel_i[0] && wb_dat_i[`ST_REJECT];

   // Bus handshake: ack and read data one cycle after the request.
   always_ff @(posedge clk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   // Read multiplexer; unmapped indices read as zero.
   always_comb begin
      case (wb_adr_i)
         `IDX_DSP_CONTROL: rd_data = {16'h0000, dsp_control_word_reg};
         `IDX_SELECTION:   rd_data = {16'h0000, selection_reg};
         `IDX_LEVEL_ABS:   rd_data = {16'h0000, level_absorber_word_reg};
         `IDX_ABSORBER:    rd_data = {16'h0000, absorber_word_reg};
         `IDX_STATUS:      rd_data = {16'h0000, pll_div_n, 7'h00, reject_reg};
         default:          rd_data = 32'h0000_0000;
      endcase
   end

   // DSP control word, holding the PLL division code.
   always_ff @(posedge clk) begin
      if (srst) begin
         dsp_control_word_reg <= `RST_DSP_CONTROL;
      end else if (wr && wb_adr_i == `IDX_DSP_CONTROL) begin
         dsp_control_word_reg <= merge(dsp_control_word_reg, wb_dat_i, wb_sel_i);
      end
   end

   // Selection word, holding audio source and format.
   always_ff @(posedge clk) begin
      if (srst) begin
         selection_reg <= `RST_SELECTION;
      end else if (wr && wb_adr_i == `IDX_SELECTION) begin
         selection_reg <= selection_next;
      end
   end

   // Level absorber word.
   always_ff @(posedge clk) begin
      if (srst) begin
         level_absorber_word_reg <= `RST_LEVEL_ABS;
      end else if (wr && wb_adr_i == `IDX_LEVEL_ABS) begin
         level_absorber_word_reg <= merge(level_absorber_word_reg, wb_dat_i, wb_sel_i);
      end
   end

   // Frequency-based absorber word.
   always_ff @(posedge clk) begin
      if (srst) begin
         absorber_word_reg <= `RST_ABSORBER;
      end else if (wr && wb_adr_i == `IDX_ABSORBER) begin
         absorber_word_reg <= merge(absorber_word_reg, wb_dat_i, wb_sel_i);
      end
   end

   // Sticky refusal flag; a new refusal wins over a clear in the same cycle.
   always_ff @(posedge clk) begin
      if (srst) begin
         reject_reg <= 1'b0;
      end else if (bad_fmt_wr) begin
         reject_reg <= 1'b1;
      end else if (reject_clr) begin
         reject_reg <= 1'b0;
      end
   end

   // Field lookups for the two absorber words.
   level_field_decode u_level_dec (
      .word (level_absorber_word_reg),
      .cfg  (level_dec)
   );

   absorber_field_decode u_absorber_dec (
      .word (absorber_word_reg),
      .cfg  (absorber_dec)
   );

   // Registered absorber settings.
   always_ff @(posedge clk) begin
      if (srst) begin
         level_cfg    <= '0;
         absorber_cfg <= '0;
      end else begin
         level_cfg    <= level_dec;
         absorber_cfg <= absorber_dec;
      end
   end

   // Registered clock generator settings.
   always_ff @(posedge clk) begin
      if (srst) begin
         pll_div_n  <= 8'd0;
         pll_bypass <= 1'b0;
      end else begin
         pll_div_n  <= pll_factor(dsp_control_word_reg[`F_PLL_HI:`F_PLL_LO]);
         pll_bypass <= dsp_control_word_reg[`F_PLL_BYPASS];
      end
   end

   // Registered audio input selection.
   always_ff @(posedge clk) begin
      if (srst) begin
         audio_source <= iac_field_pkg::src_internal_stereo_path;
         audio_format <= iac_field_pkg::fmt_internal_lsb_first;
      end else begin
         if (!selection_reg[`F_SRC_HI]) begin
            audio_source <= iac_field_pkg::src_internal_stereo_path;
         end else if (!selection_reg[`F_SRC_LO]) begin
            audio_source <= iac_field_pkg::src_external_cd_serial_input;
         end else begin
            audio_source <= iac_field_pkg::src_external_digital_audio;
         end
         if (!fmt_reserved(selection_reg[`F_FMT_HI:`F_FMT_LO])) begin
            audio_format <= fmt_decode(selection_reg[`F_FMT_HI:`F_FMT_LO]);
         end
      end
   end

   // Delayed reset keeps the checks quiet on the edge that releases reset.
   always_ff @(posedge clk) begin
      srst_d <= srst;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst || srst_d);

   // Bus answer: one ack one cycle after the request, then low.
   property p_ack_pulse;
      req |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack not a single pulse after request");

   property p_level_off;
      (level_absorber_word_reg[3:0] == 4'h0) |=> level_cfg.thr_off;
   endproperty
   a_level_off: assert property (p_level_off)
      else $error("level threshold code zero did not switch off");

   property p_level_top;
      (level_absorber_word_reg[3:0] == 4'hF) |=> !level_cfg.thr_off && level_cfg.thr_bin == 7'h40;
   endproperty
   a_level_top: assert property (p_level_top)
      else $error("level threshold code 15 not 0.5");

   property p_level_ff;
      (level_absorber_word_reg[5:4] == 2'b00) |=> level_cfg.ff_delay == -3'sd2;
   endproperty
   a_level_ff: assert property (p_level_ff)
      else $error("level feed-forward code 00 not -2");

   property p_level_stretch;
      (level_absorber_word_reg[7:6] == 2'b11) |=> level_cfg.stretch == 4'd15;
   endproperty
   a_level_stretch: assert property (p_level_stretch)
      else $error("level stretch code 11 not 15");

   property p_level_dev;
      (level_absorber_word_reg[9:8] == 2'b00) |=> level_cfg.dev_khz == 7'd42;
   endproperty
   a_level_dev: assert property (p_level_dev)
      else $error("deviation code 00 not 42 kHz");

   property p_pll_preset;
      (dsp_control_word_reg[5:2] == 4'hE) |=> pll_div_n == 8'd176;
   endproperty
   a_pll_preset: assert property (p_pll_preset)
      else $error("PLL code 1110 not 176");

   property p_pll_low;
      (dsp_control_word_reg[5:2] == 4'h0) |=> pll_div_n == 8'd93;
   endproperty
   a_pll_low: assert property (p_pll_low)
      else $error("PLL code 0000 not 93");

   property p_abs_thr;
      (absorber_word_reg[2:0] == 3'b100) |=> absorber_cfg.thr_bin == 12'h070;
   endproperty
   a_abs_thr: assert property (p_abs_thr)
      else $error("absorber threshold code 100 not 0.027");

   property p_abs_ff;
      (absorber_word_reg[5:3] == 3'b001) |=> absorber_cfg.ff_bin == 12'h030;
   endproperty
   a_abs_ff: assert property (p_abs_ff)
      else $error("feed-forward code 001 not 0.01172");

   property p_supp_none;
      (absorber_word_reg[8:6] == 3'b101) |=>
         absorber_cfg.supp_pulse == 3'd0 && !absorber_cfg.supp_stretch_valid;
   endproperty
   a_supp_none: assert property (p_supp_none)
      else $error("suppression code 101 not zero");

   property p_comp_delay;
      (absorber_word_reg[10:9] == 2'b10) |=> absorber_cfg.comp_delay == 3'd2;
   endproperty
   a_comp_delay: assert property (p_comp_delay)
      else $error("composite delay code 10 not 2");

   property p_gdc;
      (absorber_word_reg[14:12] == 3'b000) |=> absorber_cfg.gdc_delay == 4'd12;
   endproperty
   a_gdc: assert property (p_gdc)
      else $error("group delay code 000 not 12");

   property p_src_internal;
      !selection_reg[6] |=> audio_source == iac_field_pkg::src_internal_stereo_path;
   endproperty
   a_src_internal: assert property (p_src_internal)
      else $error("source upper bit 0 not internal path");

   property p_fmt_i2s;
      (selection_reg[9:7] == 3'b100) |=> audio_format == iac_field_pkg::fmt_i2s;
   endproperty
   a_fmt_i2s: assert property (p_fmt_i2s)
      else $error("format code 100 not I2S");

   property p_level_field_pos;
      (level_absorber_word_reg[3:0] == 4'h6 && level_absorber_word_reg[10]) |=>
         level_cfg.thr_bin == 7'h08 && level_cfg.sweep_en;
   endproperty
   a_level_field_pos: assert property (p_level_field_pos)
      else $error("level word field positions wrong");

   property p_abs_field_pos;
      (absorber_word_reg[14:12] == 3'b011 && absorber_word_reg[10:9] == 2'b01) |=>
         absorber_cfg.gdc_delay == 4'd15 && absorber_cfg.comp_delay == 3'd5;
   endproperty
   a_abs_field_pos: assert property (p_abs_field_pos)
      else $error("absorber word field positions wrong");

   // A refused format write leaves the stored code and then the output untouched.
   sequence s_fmt_bad_write;
      bad_fmt_wr;
   endsequence

   sequence s_fmt_hold;
      $stable(selection_reg[9:7]) && reject_reg ##1 $stable(audio_format);
   endsequence

   property p_fmt_hold;
      s_fmt_bad_write |=> s_fmt_hold;
   endproperty
   a_fmt_hold: assert property (p_fmt_hold)
      else $error("reserved format code was not refused");

endmodule

//--- host_wb.sv
`timescale 1ns/100ps

// Classic Wishbone master standing in for the host controller.
module host_wb (
   input  wire logic        clk,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [11:0]      adr,
   output logic [31:0]      dat_w,
   output logic [3:0]       sel,
   input  wire logic        ack,
   input  wire logic [31:0] dat_r
);
   // Bus idles low from time zero so nothing is taken during reset.
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = '0;
      dat_w = '0;
      sel = '0;
   end

   // One cycle: raise after an edge, hold until ack is sampled high or 20 edges pass, then release.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d,
                       input logic [3:0] s, output logic [31:0] q, output bit ok);
      int n;
      ok = 1'b0;
      q = '0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= {16'h0000, d};
      sel <= s;
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge clk);
         if (ack === 1'b1) begin
            ok = 1'b1;
            q = dat_r;
         end
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
endmodule

//--- testbench.sv
`timescale 1ns/100ps

module testbench;
   logic                         clk;
   logic                         srst;
   logic                         cyc, stb, we, ack;
   logic [11:0]                  adr;
   logic [31:0]                  dat_w, dat_r, q;
   logic [3:0]                   sel;
   iac_field_pkg::level_cfg_t    lv;
   iac_field_pkg::absorber_cfg_t ab;
   logic [7:0]                   pll_div_n;
   logic                         pll_bypass;
   iac_field_pkg::audio_source_t audio_source;
   iac_field_pkg::audio_format_t audio_format;
   int                           failures, num_checks;
   localparam logic [7:0] pll_t [16] = '{8'h5D, 8'h63, 8'h6A, 8'h71, 8'h79, 8'h7E, 8'h84,
      8'h89, 8'h8F, 8'h94, 8'h9A, 8'h9F, 8'hA5, 8'hAA, 8'hB0, 8'hB5};
   localparam logic [7:0] lthr_t [16] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08,
      8'h0A, 8'h0D, 8'h10, 8'h14, 8'h1A, 8'h20, 8'h28, 8'h34, 8'h40};
   localparam logic [3:0] lmisc_t [12] = '{4'h6, 4'h7, 4'h0, 4'h1, 4'h9, 4'hB, 4'hD, 4'hF,
      4'h2, 4'h3, 4'h9, 4'h6};
   localparam logic [11:0] athr_t [8] = '{12'h0E0, 12'h100, 12'h130, 12'h160, 12'h070,
      12'h080, 12'h09C, 12'h0C0};
   localparam logic [11:0] aff_t [8] = '{12'h000, 12'h030, 12'h020, 12'h018, 12'h010,
      12'h00C, 12'h008, 12'h006};
   localparam logic [3:0] pul_t [8] = '{4'h5, 4'h4, 4'h7, 4'h6, 4'h1, 4'h0, 4'h3, 4'h2};
   localparam logic [3:0] gdc_t [8] = '{4'hC, 4'hD, 4'hE, 4'hF, 4'h8, 4'h9, 4'hA, 4'hB};
   localparam logic [3:0] cmp_t [4] = '{4'h4, 4'h5, 4'h2, 4'h3};
   localparam logic [7:0] dev_t [4] = '{8'h2A, 8'h30, 8'h39, 8'h46};

   iac_pll_audio_field_decode u_dut (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_sel_i(sel), .wb_dat_o(dat_r),
      .wb_ack_o(ack), .level_cfg(lv), .absorber_cfg(ab), .pll_div_n(pll_div_n),
      .pll_bypass(pll_bypass), .audio_source(audio_source), .audio_format(audio_format));
   host_wb u_host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat_w(dat_w),
      .sel(sel), .ack(ack), .dat_r(dat_r));

   // Free-running 40 MHz clock.
   always #12.5 clk = ~clk;

   // Verdict and end of run.
   task summarize();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Compare one value and report a mismatch.
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Bus cycle; settled outputs are looked at on the falling edge that follows.
   task bus(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
      bit ok;
      u_host.xfer(w, a, d, s, q, ok);
      if (!ok) begin
         failures++;
         $display("wrong value ack expected 1 seen 0");
         summarize();
      end
      @(negedge clk);
   endtask

   // Decoded reset values and register read-back.
   task t_reset();
      chk("pll", 8'hB0, pll_div_n);
      chk("lthr", 8'h08, lv.thr_bin);
      chk("lff", 3'h0, $unsigned(lv.ff_delay));
      chk("lstr", 4'hD, lv.stretch);
      chk("ldev", 8'h46, lv.dev_khz);
      chk("athr", 12'h080, ab.thr_bin);
      chk("aff", 12'h030, ab.ff_bin);
      chk("astr", 3'h5, ab.supp_stretch);
      chk("acmp", 3'h5, ab.comp_delay);
      chk("agdc", 4'hC, ab.gdc_delay);
      chk("src", iac_field_pkg::src_internal_stereo_path, audio_source);
      chk("fmt", iac_field_pkg::fmt_internal_lsb_first, audio_format);
      bus(1'b0, 12'hFFC, 16'h0000, 4'h3);
      chk("lev rd", 32'h0000_7BA6, q);
      bus(1'b0, 12'hFFB, 16'h0000, 4'h3);
      chk("abs rd", 32'h0000_0ACD, q);
   endtask

   // Every PLL division code placed in bits 5 to 2.
   task t_pll();
      for (int i = 0; i < 16; i++) begin
         bus(1'b1, 12'hFFF, {10'h000, i[3:0], i[0], 1'b0}, 4'h3);
         chk("pll", pll_t[i], pll_div_n);
         chk("byp", i % 2, pll_bypass);
      end
      bus(1'b0, 12'hFFF, 16'h0000, 4'h3);
      chk("dsp rd", 32'h0000_003E, q);
   endtask

   // Every level threshold code, with the two-bit fields cycled alongside.
   task t_level();
      for (int i = 0; i < 16; i++) begin
         bus(1'b1, 12'hFFC, {5'h00, i[1], i[1:0], i[1:0], i[1:0], i[3:0]}, 4'h3);
         chk("loff", i == 0, lv.thr_off);
         if (i != 0) chk("lthr", lthr_t[i], lv.thr_bin);
         chk("lff", lmisc_t[i % 4], $unsigned(lv.ff_delay));
         chk("lstr", lmisc_t[4 + i % 4], lv.stretch);
         chk("ldev", dev_t[i % 4], lv.dev_khz);
         chk("lswp", i[1], lv.sweep_en);
      end
   endtask

   // Every absorber code in every field.
   task t_absorber();
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 12'hFFB, {i[0], i[2:0], i[1], i[2:1], i[2:0], i[2:0], i[2:0]}, 4'h3);
         chk("athr", athr_t[i], ab.thr_bin);
         chk("aff", aff_t[i], ab.ff_bin);
         chk("apul", pul_t[i], ab.supp_pulse);
         chk("aval", i != 5, ab.supp_stretch_valid);
         if (i != 5) chk("astr", pul_t[i] - 4'h1, ab.supp_stretch);
         chk("acmp", cmp_t[i[2:1]], ab.comp_delay);
         chk("aagc", i[1], ab.agc_fine);
         chk("atrg", i[0], ab.trigger_out);
         chk("agdc", gdc_t[i], ab.gdc_delay);
      end
   endtask

   // Source and format codes, reserved formats refused with the sticky flag.
   task t_select();
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 12'hFFE, {6'h00, i[2:0], i[1:0], 5'h00}, 4'h3);
         chk("fmt", (i < 6) ? i : 5, audio_format);
         chk("src", i[1] ? (i[0] ? 2 : 1) : 0, audio_source);
      end
      bus(1'b0, 12'hFFE, 16'h0000, 4'h3);
      chk("sel rd", 32'h0000_02E0, q);
      bus(1'b0, 12'hF00, 16'h0000, 4'h3);
      chk("stat", 32'h0000_B501, q);
      bus(1'b1, 12'hF00, 16'h0001, 4'h3);
      bus(1'b0, 12'hF00, 16'h0000, 4'h3);
      chk("stat", 32'h0000_B500, q);
   endtask

   // Byte lanes written apart, and an unmapped place that ignores writes.
   task t_lanes();
      bus(1'b1, 12'hFFC, 16'hFFFF, 4'h2);
      bus(1'b1, 12'hFFC, 16'h0000, 4'h1);
      chk("loff", 1'b1, lv.thr_off);
      chk("ldev", 8'h46, lv.dev_khz);
      bus(1'b0, 12'hFFC, 16'h0000, 4'h3);
      chk("lev rd", 32'h0000_FF00, q);
      bus(1'b1, 12'hFFD, 16'h1234, 4'h3);
      bus(1'b0, 12'hFFD, 16'h0000, 4'h3);
      chk("unmap", 32'h0000_0000, q);
   endtask

   // Reset for three cycles, then the scenarios in turn.
   initial begin
      clk = 1'b0;
      srst = 1'b1;
      failures = 0;
      num_checks = 0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      t_reset();
      t_pll();
      t_level();
      t_absorber();
      t_select();
      t_lanes();
      summarize();
   end
endmodule
